// File: opfm_map.svh
// opfm_map.svh: register offsets, field positions and reset values
// assumes: included by bare name from the pin mux package user files
`ifndef OPFM_MAP_SVH
`define OPFM_MAP_SVH
`define OPFM_DIR_OFF        12'h000
`define OPFM_SEL_OFF        12'h004
`define OPFM_APD_OFF        12'h008
`define OPFM_CHSEL_OFF      12'h00c
`define OPFM_OUT_OFF        12'h010
`define OPFM_IN_OFF         12'h014
`define OPFM_STAT_OFF       12'h018
`define OPFM_DIR_RST        2'h0
`define OPFM_SEL_RST        2'h3
`define OPFM_APD_RST        2'h0
`define OPFM_CHSEL_RST      3'h0
`define OPFM_OUT_RST        2'h0
`define OPFM_CH_PIN6        3'h6
`define OPFM_CH_PIN7        3'h7
`define OPFM_STAT_OE_POS    0
`define OPFM_STAT_IBUF_POS  2
`define OPFM_STAT_CMP_POS   4
`define OPFM_STAT_OSC_POS   6
`endif

// File: opfm_pkg.sv
// opfm_pkg.sv: types for the oscillator pin function mux
// assumes: nothing outside itself
package opfm_pkg;
  typedef enum logic [1:0] {
    opfm_fn_gpio,
    opfm_fn_osc,
    opfm_fn_analog
  } opfm_fn_t;
endpackage

// File: opfm_pin_cell.sv
// opfm_pin_cell.sv: function decode of one shared pin
// assumes: control inputs are registered on sys_clk
`timescale 1ns/1ps
module opfm_pin_cell #(
  parameter bit IS_OUTPUT_OSC = 1'b0
) (
  // control
  input  wire logic              dir,
  input  wire logic              func_sel,
  input  wire logic              analog_dis,
  input  wire logic              cmp_chosen,
  // function sources
  input  wire logic              gpio_out,
  input  wire logic              osc_out,
  // pad
  input  wire logic              pad_in,
  output logic                   pad_out,
  output logic                   pad_oe_n,
  // results
  output logic                   in_value,
  output logic                   osc_in,
  output logic                   ibuf_en,
  output opfm_pkg::opfm_fn_t     fn
);
  always_comb begin
    if (analog_dis) begin
      fn = opfm_pkg::opfm_fn_analog;
    end else if (func_sel) begin
      fn = opfm_pkg::opfm_fn_osc;
    end else begin
      fn = opfm_pkg::opfm_fn_gpio;
    end
  end
  always_comb begin
    pad_out  = 1'b0;
    pad_oe_n = 1'b1;
    case (fn)
      opfm_pkg::opfm_fn_gpio: begin
        pad_out  = gpio_out;
        pad_oe_n = ~dir;                          // [RULE_01] [RULE_02]
      end
      opfm_pkg::opfm_fn_osc: begin
        pad_out  = IS_OUTPUT_OSC ? osc_out : 1'b0;
        pad_oe_n = ~IS_OUTPUT_OSC;                // [RULE_03] [RULE_04]
      end
      opfm_pkg::opfm_fn_analog: begin
        pad_out  = 1'b0;
        pad_oe_n = 1'b1;                          // [RULE_06]
      end
      default: begin
        pad_out  = 1'b0;
        pad_oe_n = 1'b1;
      end
    endcase
  end
  // input buffer off in analog use or when chosen by comparator
  assign ibuf_en  = ~analog_dis & ~cmp_chosen;    // [RULE_06] [RULE_09]
  assign in_value = ibuf_en & pad_in;             // [RULE_11]
  assign osc_in   = (~IS_OUTPUT_OSC && fn == opfm_pkg::opfm_fn_osc) ? pad_in : 1'b0;  // [RULE_03]
endmodule

// File: opfm_top.sv
// opfm_top.sv: function mux of the two crystal oscillator port pins
// assumes: one ahb-lite master, 50 MHz sys_clk, async active-low reset
//
// Contract
// RULE_01: pin six digital I/O, direction bit
// RULE_02: pin seven digital I/O, direction bit
// RULE_03: pin six select gives oscillator input
// RULE_04: pin seven select gives oscillator output
// RULE_05: reset selects oscillator on both pins
// RULE_06: analog disable kills driver and trigger
// RULE_07: channel code 110 routes pin six
// RULE_08: channel code 111 routes pin seven
// RULE_09: comparator choice disables input buffer
// RULE_10: software clears select before pin seven input
// RULE_11: disabled buffer reads as low
`timescale 1ns/1ps
`include "opfm_map.svh"
module opfm_top (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // ahb-lite slave
  input  wire logic         hsel,
  input  wire logic [11:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // oscillator core
  input  wire logic         osc_drive,
  output logic              crystal_osc_input,
  // comparator
  output logic              comparator_channel_six,
  output logic              comparator_channel_seven,
  // pads, index 0 is pin six, index 1 pin seven
  input  wire logic [1:0]   pad_in,
  output logic [1:0]        pad_out,
  output logic [1:0]        pad_oe_n
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [1:0]  port_two_direction_r, port_two_direction_nxt;
  logic [1:0]  port_two_function_select_r, port_two_function_select_nxt;
  logic [1:0]  comparator_pin_analog_disable_r, comparator_pin_analog_disable_nxt;
  logic [2:0]  chan_sel_r, chan_sel_nxt;
  logic [1:0]  out_data_r, out_data_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic        wr_r, wr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [1:0]  in_value;
  logic [1:0]  ibuf_en;
  logic [1:0]  cmp_chosen;
  logic [1:0]  osc_in;
  logic [2:0]  sync0_r, sync0_nxt, sync1_r, sync1_nxt;
  logic [1:0]  in_stable_r, in_stable_nxt;
  logic        comparator_chan_sel_bit1, comparator_chan_sel_bit2, comparator_chan_sel_bit3;
  logic        take;
  logic [7:0]  status;
  opfm_pkg::opfm_fn_t fn [2];

  assign comparator_chan_sel_bit1 = chan_sel_r[0];
  assign comparator_chan_sel_bit2 = chan_sel_r[1];
  assign comparator_chan_sel_bit3 = chan_sel_r[2];
  assign cmp_chosen[0] = comparator_chan_sel_bit3 & comparator_chan_sel_bit2 & ~comparator_chan_sel_bit1; // [RULE_07]
  assign cmp_chosen[1] = comparator_chan_sel_bit3 & comparator_chan_sel_bit2 & comparator_chan_sel_bit1;  // [RULE_08]
  assign comparator_channel_six   = cmp_chosen[0] & pad_in[0];  // [RULE_07]
  assign comparator_channel_seven = cmp_chosen[1] & pad_in[1];  // [RULE_08]
  assign crystal_osc_input        = osc_in[0];

  // ------------------------------------------------------------
  // pin cells
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      opfm_pin_cell #(
        .IS_OUTPUT_OSC (g == 1)
      ) u_cell (
        .dir        (port_two_direction_r[g]),
        .func_sel   (port_two_function_select_r[g]),
        .analog_dis (comparator_pin_analog_disable_r[g]),
        .cmp_chosen (cmp_chosen[g]),
        .gpio_out   (out_data_r[g]),
        .osc_out    (osc_drive),
        .pad_in     (pad_in[g]),
        .pad_out    (pad_out[g]),
        .pad_oe_n   (pad_oe_n[g]),
        .in_value   (in_value[g]),
        .osc_in     (osc_in[g]),
        .ibuf_en    (ibuf_en[g]),
        .fn         (fn[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // status word
  // ------------------------------------------------------------
  always_comb begin
    status                           = 8'h00;
    status[`OPFM_STAT_OE_POS +: 2]   = ~pad_oe_n;
    status[`OPFM_STAT_IBUF_POS +: 2] = ibuf_en;
    status[`OPFM_STAT_CMP_POS +: 2]  = cmp_chosen;
    status[`OPFM_STAT_OSC_POS]       = (fn[0] == opfm_pkg::opfm_fn_osc);
    status[`OPFM_STAT_OSC_POS + 1]   = (fn[1] == opfm_pkg::opfm_fn_osc);
  end

  // ------------------------------------------------------------
  // input synchroniser, three stages, agree on last two
  // ------------------------------------------------------------
  // first stage feeds only the second
  always_comb begin
    sync0_nxt     = {sync0_r[1:0], in_value[0]};
    sync1_nxt     = {sync1_r[1:0], in_value[1]};
    in_stable_nxt = in_stable_r;
    if (sync0_r[2] == sync0_r[1]) begin
      in_stable_nxt[0] = sync0_r[1];
    end
    if (sync1_r[2] == sync1_r[1]) begin
      in_stable_nxt[1] = sync1_r[1];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync0_r     <= 3'h0;
      sync1_r     <= 3'h0;
      in_stable_r <= 2'h0;
    end else begin
      sync0_r     <= sync0_nxt;
      sync1_r     <= sync1_nxt;
      in_stable_r <= in_stable_nxt;
    end
  end

  // ------------------------------------------------------------
  // control registers, written in the data phase
  // ------------------------------------------------------------
  always_comb begin
    port_two_direction_nxt            = port_two_direction_r;
    port_two_function_select_nxt      = port_two_function_select_r;
    comparator_pin_analog_disable_nxt = comparator_pin_analog_disable_r;
    chan_sel_nxt                      = chan_sel_r;
    out_data_nxt                      = out_data_r;
    if (wr_r) begin
      case (addr_r)
        `OPFM_DIR_OFF:   port_two_direction_nxt = hwdata[1:0];
        `OPFM_SEL_OFF:   port_two_function_select_nxt = hwdata[1:0];
        `OPFM_APD_OFF:   comparator_pin_analog_disable_nxt = hwdata[1:0];
        `OPFM_CHSEL_OFF: chan_sel_nxt = hwdata[3:1];
        `OPFM_OUT_OFF:   out_data_nxt = hwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_two_direction_r            <= `OPFM_DIR_RST;
      port_two_function_select_r      <= `OPFM_SEL_RST;  // [RULE_05]
      comparator_pin_analog_disable_r <= `OPFM_APD_RST;
      chan_sel_r                      <= `OPFM_CHSEL_RST;
      out_data_r                      <= `OPFM_OUT_RST;
    end else begin
      port_two_direction_r            <= port_two_direction_nxt;
      port_two_function_select_r      <= port_two_function_select_nxt;
      comparator_pin_analog_disable_r <= comparator_pin_analog_disable_nxt;
      chan_sel_r                      <= chan_sel_nxt;
      out_data_r                      <= out_data_nxt;
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait, always okay
  // ------------------------------------------------------------
  assign take = hsel & hready & htrans[1];
  always_comb begin
    addr_nxt   = take ? haddr : addr_r;
    wr_nxt     = take & hwrite;
    hrdata_nxt = hrdata_r;
    // next values, so a read right behind a write sees it
    if (take & ~hwrite) begin
      case (haddr)
        `OPFM_DIR_OFF:   hrdata_nxt = {30'h0, port_two_direction_nxt};
        `OPFM_SEL_OFF:   hrdata_nxt = {30'h0, port_two_function_select_nxt};
        `OPFM_APD_OFF:   hrdata_nxt = {30'h0, comparator_pin_analog_disable_nxt};
        `OPFM_CHSEL_OFF: hrdata_nxt = {28'h0, chan_sel_nxt, 1'b0};
        `OPFM_OUT_OFF:   hrdata_nxt = {30'h0, out_data_nxt};
        `OPFM_IN_OFF:    hrdata_nxt = {30'h0, in_stable_r};
        `OPFM_STAT_OFF:  hrdata_nxt = {24'h0, status};
        default:         hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r   <= 12'h000;
      wr_r     <= 1'b0;
      hrdata_r <= 32'h0;
    end else begin
      addr_r   <= addr_nxt;
      wr_r     <= wr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
endmodule

// File: opfm_top_asserts.sv
// opfm_top_asserts.sv: port checks of the pin mux
// assumes: bound to opfm_top, one clock domain
`timescale 1ns/1ps
`include "opfm_map.svh"
module opfm_top_asserts (
  // clock, reset, bus
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // pins
  input wire logic        osc_drive,
  input wire logic        crystal_osc_input,
  input wire logic        comparator_channel_six,
  input wire logic        comparator_channel_seven,
  input wire logic [1:0]  pad_in,
  input wire logic [1:0]  pad_out,
  input wire logic [1:0]  pad_oe_n
);
  logic [11:0] wa_r, wa_nxt;
  logic        wv_r, wv_nxt;
  logic [1:0]  dir_r, dir_nxt, sel_r, sel_nxt, apd_r, apd_nxt;
  logic [2:0]  ch_r, ch_nxt;
  // shadow of the control registers except output data
  always_comb begin
    wv_nxt = hsel && hready && htrans[1] && hwrite;
    wa_nxt = haddr;
    dir_nxt = (wv_r && wa_r == `OPFM_DIR_OFF) ? hwdata[1:0] : dir_r;
    sel_nxt = (wv_r && wa_r == `OPFM_SEL_OFF) ? hwdata[1:0] : sel_r;
    apd_nxt = (wv_r && wa_r == `OPFM_APD_OFF) ? hwdata[1:0] : apd_r;
    ch_nxt = (wv_r && wa_r == `OPFM_CHSEL_OFF) ? hwdata[3:1] : ch_r;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {wv_r, wa_r, dir_r, sel_r, apd_r, ch_r} <= {15'h0, `OPFM_SEL_RST, 5'h0};
    end else begin
      {wv_r, wa_r, dir_r, sel_r, apd_r, ch_r} <= {wv_nxt, wa_nxt, dir_nxt, sel_nxt, apd_nxt, ch_nxt};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_gpio6; !sel_r[0] && !apd_r[0]; endsequence
  sequence s_gpio7; !sel_r[1] && !apd_r[1]; endsequence
  property p_gpio6; s_gpio6 |-> pad_oe_n[0] == !dir_r[0]; endproperty
  a_gpio6: assert property (p_gpio6) else $error("pin six gpio");
  property p_gpio7; s_gpio7 |-> pad_oe_n[1] == !dir_r[1]; endproperty
  a_gpio7: assert property (p_gpio7) else $error("pin seven gpio");
  property p_osc6; sel_r[0] && !apd_r[0] |-> pad_oe_n[0] && crystal_osc_input == pad_in[0]; endproperty
  a_osc6: assert property (p_osc6) else $error("pin six osc");
  property p_osc7; sel_r[1] && !apd_r[1] |-> !pad_oe_n[1] && pad_out[1] == osc_drive; endproperty
  a_osc7: assert property (p_osc7) else $error("pin seven osc");
  property p_rst; $rose(reset_n) |-> pad_oe_n == 2'b01; endproperty
  a_rst: assert property (p_rst) else $error("reset function");
  property p_apd; |apd_r |-> (apd_r & ~pad_oe_n) == 2'b00 && !(apd_r[0] && crystal_osc_input); endproperty
  a_apd: assert property (p_apd) else $error("analog disable");
  property p_ch6; ch_r == 3'b110 |-> comparator_channel_six == pad_in[0] && !comparator_channel_seven; endproperty
  a_ch6: assert property (p_ch6) else $error("channel six");
  property p_ch7; ch_r == 3'b111 |-> comparator_channel_seven == pad_in[1] && !comparator_channel_six; endproperty
  a_ch7: assert property (p_ch7) else $error("channel seven");
endmodule
bind opfm_top opfm_top_asserts i_opfm_top_asserts (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .osc_drive, .crystal_osc_input, .comparator_channel_six, .comparator_channel_seven, .pad_in, .pad_out,
  .pad_oe_n);

// File: opfm_pad_model.sv
// opfm_pad_model.sv: pad wires with outside crystal or analog source
// assumes: source level set by the bench, design wins while driving
`timescale 1ns/1ps
module opfm_pad_model (
  // design side
  input wire logic [1:0] pad_out,
  input wire logic [1:0] pad_oe_n,
  // outside source
  input wire logic [1:0] src_level,
  output logic [1:0]     pad_in
);
  assign pad_in = (pad_out & ~pad_oe_n) | (src_level & pad_oe_n);
endmodule

// File: osc_pin_function_mux_test.sv
// osc_pin_function_mux_test.sv: self-checking bench of the pin mux
// assumes: design, pad model and checker compiled before
`timescale 1ns/1ps
`include "opfm_map.svh"
module osc_pin_function_mux_test;
  logic sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, osc_drive;
  logic crystal_osc_input, comparator_channel_six, comparator_channel_seven;
  logic [11:0] haddr;
  logic [1:0]  htrans, pad_in, pad_out, pad_oe_n, src_level;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, seed;
  int          n_errors, total_checks;
  logic [11:0] offs [5] = '{`OPFM_SEL_OFF, `OPFM_DIR_OFF, `OPFM_APD_OFF, `OPFM_CHSEL_OFF, `OPFM_OUT_OFF};
  logic [13:0] corner [6] = '{14'h3012, 14'h001d, 14'h3c07, 14'h3f1b, 14'h00c6, 14'h00e6};
  opfm_top i_opfm_top (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .osc_drive, .crystal_osc_input, .comparator_channel_six, .comparator_channel_seven, .pad_in,
    .pad_out, .pad_oe_n);
  opfm_pad_model i_opfm_pad_model (.pad_out, .pad_oe_n, .src_level, .pad_in);
  assign hready = hreadyout;
  always #10 sys_clk = ~sys_clk;
  // ----
  // bus and checks
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic oe_n(input int i, input logic [13:0] v);
    return v[8+i] || (v[10+i] ? (i == 0) : !v[12+i]);
  endfunction
  function automatic logic lvl(input int i, input logic [13:0] v);
    return oe_n(i, v) ? v[1+i] : (v[10+i] && i == 1) ? v[0] : v[3+i];
  endfunction
  function automatic logic dis(input int i, input logic [13:0] v);
    return v[8+i] || v[7:5] == {2'b11, i[0]};
  endfunction
  function automatic logic [31:0] stat(input logic [13:0] v);
    logic [1:0] drv, ib, ch, osc;
    for (int i = 0; i < 2; i++) begin
      drv[i] = !oe_n(i, v);
      ch[i]  = v[7:5] == {2'b11, i[0]};
      ib[i]  = !v[8+i] && !ch[i];
      osc[i] = v[10+i] && !v[8+i];
    end
    return {24'h0, osc, ch, ib, drv};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("reset oe", 32'h1, pad_oe_n);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, offs[i], 32'h0);
      chk("reset value", (i == 0) ? 32'h3 : 32'h0, rd);
    end
    chk("reset osc out", osc_drive, pad_out[1]);
    $display("reset test done");
  endtask
  task automatic run_vec(input logic [13:0] v);
    logic [31:0] wv [5];
    wv = '{{30'h0, v[11:10]}, {30'h0, v[13:12]}, {30'h0, v[9:8]}, {28'h0, v[7:5], 1'b0}, {30'h0, v[4:3]}};
    src_level <= v[2:1];
    osc_drive <= v[0];
    for (int i = 0; i < 5; i++) xfer(1'b1, offs[i], wv[i]);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, offs[i], 32'h0);
      chk("readback", wv[i], rd);
    end
    xfer(1'b0, `OPFM_IN_OFF, 32'h0);
    for (int i = 0; i < 2; i++) begin
      chk("pad_oe_n", oe_n(i, v), pad_oe_n[i]);
      if (!oe_n(i, v)) chk("pad_out", lvl(i, v), pad_out[i]);
      if (dis(i, v) || !v[10+i]) chk("input", dis(i, v) ? 1'b0 : lvl(i, v), rd[i]);
    end
    chk("osc in", (v[10] && !v[8]) ? v[1] : 1'b0, crystal_osc_input);
    chk("cmp six", (v[7:5] == 3'b110) ? lvl(0, v) : 1'b0, comparator_channel_six);
    chk("cmp seven", (v[7:5] == 3'b111) ? lvl(1, v) : 1'b0, comparator_channel_seven);
    xfer(1'b0, `OPFM_STAT_OFF, 32'h0);
    chk("status", stat(v), rd);
    $display("vector %h done", v);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    {hsel, hwrite, osc_drive, haddr, htrans, src_level} = '0;
    hsize = 3'b010;
    hwdata = 32'h0;
    seed = 32'h12ae584e;
    do_reset();
    xfer(1'b1, 12'h01c, 32'hffffffff);
    xfer(1'b0, 12'h01c, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("unmapped test done");
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      run_vec((k < 6) ? corner[k] : seed[13:0]);
    end
    do_reset();
    give_verdict();
  end
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
endmodule
